//--- hdl/scpd_pkg.sv
// Purpose: Constants for the card presence detect block
// Assumes: One 20 MHz clock, synchronous active-low reset
// Notes:   Settings are plain inputs; no software-visible registers
package scpd_pkg;
  localparam logic       HOT_PLUG_RESET = 1'b1;
  localparam logic       POLARITY_HIGH  = 1'b1;
  localparam int         SYNC_STAGES    = 2;
  localparam logic [1:0] SYNC_RESET     = 2'h0;
  typedef enum logic [2:0] {
    SCPD_NO_CARD,
    SCPD_INIT,
    SCPD_REG,
    SCPD_READY
  } scpd_state_t;
endpackage

//--- hdl/scpd_sync.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Input may change at any time
// Notes:   First stage is read only by the second
module scpd_sync
  import scpd_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  // Level
  input  wire logic level_i,
  output logic      level_o
);
  logic [1:0] stage;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      stage <= SYNC_RESET;
    end else begin
      stage <= {stage[0], level_i};
    end
  end

  assign level_o = stage[1];
endmodule

//--- hdl/scpd_top.sv
// Purpose: Card slot hot-plug presence detection and card session control
// Assumes: Card handler reports init done; settings are static levels
// Notes:   Start-up sample is taken on the first synchronised cycle after reset
module scpd_top
  import scpd_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  // Slot and settings
  input  wire logic card_detect_in_i,
  input  wire logic hot_plug_enable_setting_i,
  input  wire logic detect_polarity_setting_i,
  // Card handler
  input  wire logic card_info_read_i,
  output logic      card_present_o,
  output logic      card_init_start_o,
  output logic      card_access_en_o,
  output logic      net_register_o
);
  logic        det_sync;
  logic        det_active;
  logic        boot_sampled;
  logic        boot_present;
  logic        present;
  scpd_state_t state;

  scpd_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .level_i   (card_detect_in_i),
    .level_o   (det_sync)
  );

  // Active level: polarity 1 high-active, 0 low-active
  assign det_active = detect_polarity_setting_i ? det_sync : !det_sync;

  // Wait for synchroniser to fill before the start-up sample
  logic [1:0] fill;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      fill         <= 2'h0;
      boot_sampled <= 1'b0;
      boot_present <= 1'b0;
    end else if (fill != 2'h2) begin
      fill <= fill + 2'h1;
    end else if (!boot_sampled) begin
      boot_sampled <= 1'b1;
      boot_present <= det_active;
    end
  end

  // Enabled: follow detect level; disabled: hold start-up sample
  assign present = hot_plug_enable_setting_i ? det_active : boot_present;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state             <= SCPD_NO_CARD;
      card_init_start_o <= 1'b0;
      net_register_o    <= 1'b0;
    end else begin
      card_init_start_o <= 1'b0;
      net_register_o    <= 1'b0;
      if (!boot_sampled) begin
        state <= SCPD_NO_CARD;
      end else if (!present) begin
        state <= SCPD_NO_CARD;
      end else begin
        case (state)
          SCPD_NO_CARD: begin
            state             <= SCPD_INIT;
            card_init_start_o <= 1'b1;
          end
          SCPD_INIT: begin
            if (card_info_read_i) begin
              state          <= SCPD_REG;
              net_register_o <= 1'b1;
            end
          end
          // Registration has been triggered; the session is now up
          SCPD_REG: begin
            state <= SCPD_READY;
          end
          SCPD_READY: state <= SCPD_READY;
          default:    state <= SCPD_NO_CARD;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      card_present_o   <= 1'b0;
      card_access_en_o <= 1'b0;
    end else begin
      card_present_o   <= boot_sampled && present;
      card_access_en_o <= boot_sampled && present;
    end
  end

  property p_remove;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (boot_sampled && hot_plug_enable_setting_i && !det_active) |=> !card_access_en_o;
  endproperty
  card_removal_stop_a: assert property (p_remove)
    else $error("card access not stopped on removal");

  init_on_insert_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (state == SCPD_NO_CARD && boot_sampled && present) |=> card_init_start_o)
    else $error("init not started on insertion");

  register_after_info_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      net_register_o |-> $past(state) == SCPD_INIT && $past(card_info_read_i))
    else $error("registration without card info");

  disabled_ignore_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (boot_sampled && !hot_plug_enable_setting_i) |=> card_present_o == boot_present)
    else $error("detect input not ignored when disabled");

  polarity_high_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (boot_sampled && hot_plug_enable_setting_i && detect_polarity_setting_i)
        |=> card_present_o == $past(det_sync))
    else $error("active-high presence wrong");

  polarity_low_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (boot_sampled && hot_plug_enable_setting_i && !detect_polarity_setting_i)
        |=> card_present_o == !$past(det_sync))
    else $error("active-low presence wrong");

  absent_high_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (hot_plug_enable_setting_i && detect_polarity_setting_i && !det_sync)
        |=> !card_present_o)
    else $error("low level shown as present");

  sync_delay_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(det_sync) |-> $past(card_detect_in_i, 2))
    else $error("detect not synchronised");

  start_state_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !boot_sampled |-> state == SCPD_NO_CARD && !card_access_en_o)
    else $error("activity before start-up sample");

  // Session, output shape and start-up sample checks
  access_follows_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      card_access_en_o == card_present_o)
    else $error("access enable differs from presence");

  property p_init_pulse;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      card_init_start_o |=> !card_init_start_o;
  endproperty
  init_pulse_a: assert property (p_init_pulse)
    else $error("init start longer than one cycle");

  property p_register_pulse;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      net_register_o |=> !net_register_o;
  endproperty
  register_pulse_a: assert property (p_register_pulse)
    else $error("registration longer than one cycle");

  property p_init_cause;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      card_init_start_o |-> $past(present) && $past(state) == SCPD_NO_CARD;
  endproperty
  init_needs_card_a: assert property (p_init_cause)
    else $error("init started without a card");

  property p_info_ignored;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (state != SCPD_INIT && card_info_read_i) |=> !net_register_o;
  endproperty
  info_ignored_a: assert property (p_info_ignored)
    else $error("registration outside init");

  property p_removal_idle;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (boot_sampled && !present) |=> state == SCPD_NO_CARD;
  endproperty
  removal_idle_a: assert property (p_removal_idle)
    else $error("session kept after removal");

  property p_boot_stable;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      boot_sampled |=> boot_sampled && $stable(boot_present);
  endproperty
  boot_stable_a: assert property (p_boot_stable)
    else $error("start-up sample changed");

  sync_fill_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (fill != 2'h2) |-> !boot_sampled)
    else $error("sample taken before synchroniser filled");

  property p_enabled_follow;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (boot_sampled && hot_plug_enable_setting_i) |=> card_present_o == $past(det_active);
  endproperty
  enabled_follow_a: assert property (p_enabled_follow)
    else $error("presence not following detect level");

  low_absent_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (hot_plug_enable_setting_i && !detect_polarity_setting_i && det_sync)
        |=> !card_present_o)
    else $error("high level shown as present when active low");

  property p_reg_state;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      state == SCPD_REG |=> state == SCPD_READY || state == SCPD_NO_CARD;
  endproperty
  reg_state_a: assert property (p_reg_state)
    else $error("registration state not left");

  single_init_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      state == SCPD_READY |-> !card_init_start_o)
    else $error("init restarted while ready");

  cover_insert_c:   cover property (@(posedge sys_clk_i) card_init_start_o);
  cover_register_c: cover property (@(posedge sys_clk_i) net_register_o);
  cover_remove_c:   cover property (@(posedge sys_clk_i) $fell(card_access_en_o));
  cover_low_c:      cover property (@(posedge sys_clk_i)
      !detect_polarity_setting_i && card_present_o);
  cover_disabled_c: cover property (@(posedge sys_clk_i)
      !hot_plug_enable_setting_i && boot_sampled && card_present_o);
endmodule

//--- test/scpd_slot_model.sv
// Purpose: Card slot with optional detect switch
// Assumes: Switch wiring follows the selected active level
// Notes:   Without a switch the detect pin is held low
module scpd_slot_model (
  // Slot state
  input  wire logic inserted_i,
  input  wire logic has_switch_i,
  input  wire logic active_high_i,
  // Detect pin
  output logic      detect_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Level meaning card present follows polarity
  assign detect_o = has_switch_i & (inserted_i ~^ active_high_i);
endmodule

//--- test/testbench.sv
// Purpose: Self-checking bench for card presence detection
// Assumes: Outputs settle within five cycles of a pin change
// Notes:   Pulses are counted as they pass
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, ins = 1'b0, sw = 1'b1, hp = 1'b1, pol = 1'b1, rd = 1'b0;
  logic det, present, init_start, access, net_reg;
  int   err_total = 0, n_tests = 0, cyc = 0, n_init = 0, n_reg = 0;
  always #25 clk = ~clk;
  scpd_slot_model scpd_slot_model_i (.inserted_i(ins), .has_switch_i(sw),
    .active_high_i(pol), .detect_o(det));
  scpd_top scpd_top_i (.sys_clk_i(clk), .reset_n_i(rst_n), .card_detect_in_i(det),
    .hot_plug_enable_setting_i(hp), .detect_polarity_setting_i(pol),
    .card_info_read_i(rd), .card_present_o(present), .card_init_start_o(init_start),
    .card_access_en_o(access), .net_register_o(net_reg));
  always @(negedge clk) begin
    cyc++;
    n_init += int'(init_start === 1'b1);
    n_reg += int'(net_reg === 1'b1);
    if (cyc == 2000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic boot(input logic h, input logic p, input logic s, input logic i);
    rst_n = 1'b0;
    {hp, pol, sw, ins} = {h, p, s, i};
    step(6);
    n_init = 0;
    n_reg = 0;
    rst_n = 1'b1;
    step(6);
  endtask
  task automatic t_insert_remove();
    boot(1'b1, 1'b1, 1'b1, 1'b0);
    chk({present, access}, 8'h00);
    ins = 1'b1;
    step(5);
    chk({present, access, n_init[5:0]}, 8'hC1);
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    step(2);
    chk(n_reg[7:0], 8'h01);
    rd = 1'b1;
    step(2);
    rd = 1'b0;
    chk(n_reg[7:0], 8'h01);
    ins = 1'b0;
    step(5);
    chk({present, access}, 8'h00);
    ins = 1'b1;
    step(5);
    chk(n_init[7:0], 8'h02);
  endtask
  task automatic t_polarity();
    boot(1'b1, 1'b0, 1'b1, 1'b1);
    chk(present, 1'b1);
    ins = 1'b0;
    step(5);
    chk(present, 1'b0);
  endtask
  task automatic t_disabled();
    boot(1'b0, 1'b1, 1'b1, 1'b1);
    chk(present, 1'b1);
    ins = 1'b0;
    step(5);
    chk(present, 1'b1);
    hp = 1'b1;
    step(5);
    chk(present, 1'b0);
    boot(1'b0, 1'b1, 1'b0, 1'b1);
    chk({present, n_init[6:0]}, 8'h00);
  endtask
  task automatic results();
    $display("errors %0d tests %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    t_insert_remove();
    t_polarity();
    t_disabled();
    results();
  end
endmodule
